/* adc_serial_pkg.sv */
/*
  Shared constants, bus carriers and default filter taps for the
  sigma-delta result path and its serial output port.
  Assumes a single 100 MHz clock; master clock is modelled as clk/2.
*/
// Operation
// - divide-by-1: internal tick and shift clock both run at master clock
// - divide-by-2: internal tick at half master; shift clock half or full per rate pin
// - ready output goes low for exactly one shift clock period per result
// - polarity 0: bits change on rising shift clock, host samples falling edge
// - a transfer spans 32 shift periods: 24 data bits then 7 status bits
// - status order: address 3 bits, valid, overrange, low power, filter ok
// - valid status bit set only when the word shifted out is valid
// - frame mark low 32 shift periods, starting after ready rises
// - data output released during last frame period, so 31 bits per result
// - decimate-32: frame pulses only for halve low and rate high, else low
// - half word latch output pulses after every 16 bit periods
// - modulator delivers one sample to the filter every internal tick
// - three filter stages in series, first decimates by fixed four
// - second stage decimates by 8, 16 or 32
// - third stage decimates by two with default or loaded taps, may be bypassed
// - four output rates, internal rate divided by total decimation
// - after restart valid waits twice filter delay plus computation delay
`default_nettype none
package adc_serial_pkg;
  localparam int DATA_W = 24;
  localparam int SAMPLE_W = 16;
  localparam int ACC_W = 32;
  localparam int WORD_W = 31;
  localparam int FRAME_LEN = 32;
  localparam int TAPS = 8;
  localparam int TAP_AW = 3;
  localparam int COEF_W = 8;
  localparam int COEF_FRAC = 7;
  localparam int MAC_W = 36;
  localparam logic [2:0] STAGE1_SHIFT = 3'h2;
  localparam logic [2:0] STAGE2_SHIFT_MIN = 3'h3;
  localparam logic [1:0] DEC_SEL_MAX = 2'h2;
  localparam logic [2:0] STAGE3_SHIFT = 3'h3;
  localparam logic [11:0] COMP_DELAY_TICKS = 12'h006;
  localparam logic [3:0] HALF_MARK = 4'hF;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFS_RESULT = 8'h10;
  localparam logic [7:0] OFS_COEF = 8'h20;
  localparam logic [7:0] OFS_COEF_END = 8'h3C;
  localparam int CTRL_DEC_LSB = 0;
  localparam int CTRL_BYPASS = 2;
  localparam int CTRL_USER_COEF = 3;
  localparam int CTRL_LOW_POWER = 4;
  localparam int CTRL_ADR_LSB = 5;
  localparam int STAT_VALID = 0;
  localparam int STAT_OVERRANGE = 1;
  localparam int STAT_FILTER_OK = 2;
  localparam int STAT_BUSY = 3;
  localparam int IRQ_W = 3;
  localparam int IRQ_RESULT = 0;
  localparam int IRQ_OVERRANGE = 1;
  localparam int IRQ_VALID = 2;
  localparam logic [TAPS-1:0][COEF_W-1:0] DEF_COEF = {
    8'h06, 8'h0E, 8'h14, 8'h18, 8'h18, 8'h14, 8'h0E, 8'h06};
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_s;
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_s;
endpackage : adc_serial_pkg
`default_nettype wire

/* decim_stage.sv */
/*
  Accumulate-and-dump decimating stage (boxcar FIR), factor 2**shift.
  Assumes in_valid_i is a one-cycle strobe and shift_i is at most 7.
*/
`timescale 1ns/1ns
`default_nettype none
module decim_stage (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic restart_i,
  input wire logic [2:0] shift_i,
  input wire logic in_valid_i,
  input wire logic [adc_serial_pkg::DATA_W-1:0] in_data_i,
  output var logic out_valid_o,
  output var logic [adc_serial_pkg::DATA_W-1:0] out_data_o
);
  import adc_serial_pkg::*;
  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic [7:0] cnt;
    logic v;
    logic [DATA_W-1:0] d;
  } stage_s;
  stage_s r, n;
  logic [7:0] last_cnt;
  logic [ACC_W-1:0] sum;

  always_comb begin
    n = r;
    n.v = 1'b0;
    last_cnt = (8'h01 << shift_i) - 8'h01;
    sum = r.acc + ACC_W'($signed(in_data_i));
    if (restart_i) begin
      n.acc = '0;
      n.cnt = '0;
    end else if (in_valid_i) begin
      if (r.cnt == last_cnt) begin
        // averaging keeps the word at full scale, no gain per stage
        n.d = sum[shift_i +: DATA_W];
        n.v = 1'b1;
        n.acc = '0;
        n.cnt = '0;
      end else begin
        n.acc = sum;
        n.cnt = r.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) r <= '0;
    else r <= n;
  end

  assign out_valid_o = r.v;
  assign out_data_o = r.d;

  AST_STAGE_DUMP: assert property (@(posedge clk_i) disable iff (rst_i)
    out_valid_o |-> $past(r.cnt) == $past(last_cnt))
    else $error("stage output not at end of decimation window");
endmodule : decim_stage
`default_nettype wire

/* coef_mem.sv */
/*
  Small tap memory for the loadable third filter stage.
  Read data come out of a register one cycle after the address.
*/
`timescale 1ns/1ns
`default_nettype none
module coef_mem (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_en_i,
  input wire logic [adc_serial_pkg::TAP_AW-1:0] wr_addr_i,
  input wire logic [adc_serial_pkg::COEF_W-1:0] wr_data_i,
  input wire logic [adc_serial_pkg::TAP_AW-1:0] rd_addr_i,
  output var logic [adc_serial_pkg::COEF_W-1:0] rd_data_o
);
  import adc_serial_pkg::*;
  typedef struct packed {
    logic [TAPS-1:0][COEF_W-1:0] mem;
    logic [COEF_W-1:0] rd;
  } cmem_s;
  cmem_s r, n;

  always_comb begin
    n = r;
    if (wr_en_i) n.mem[wr_addr_i] = wr_data_i;
    n.rd = r.mem[rd_addr_i];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) r <= '0;
    else r <= n;
  end

  assign rd_data_o = r.rd;
endmodule : coef_mem
`default_nettype wire

/* adc_result_serial_output.sv */
/*
  Decimating filter chain and serial result port of a sigma-delta
  converter, with a classic Wishbone register slave and interrupt.
  Assumes strap pins are asynchronous; modulator samples are on clk_i.
*/
`timescale 1ns/1ns
`default_nettype none
module adc_result_serial_output (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire adc_serial_pkg::wb_req_s wb_req_i,
  output var adc_serial_pkg::wb_rsp_s wb_rsp_o,
  output var logic irq_o,
  input wire logic [adc_serial_pkg::SAMPLE_W-1:0] mod_sample_i,
  output var logic mod_sample_take_o,
  input wire logic clock_halve_select_n_i,
  input wire logic shift_rate_select_i,
  input wire logic shift_edge_polarity_i,
  output var logic shift_clock_out_o,
  output var logic result_bit_out_o,
  output var logic result_bit_out_oe_o,
  output var logic result_ready_n_o,
  output var logic frame_mark_out_n_o,
  output var logic half_word_latch_out_o
);
  import adc_serial_pkg::*;
  typedef enum logic [1:0] {SER_IDLE, SER_READY, SER_FRAME} ser_e;
  typedef struct packed {
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    logic [1:0] div_cnt;
    logic shift_clk;
    logic ack;
    logic [31:0] rdata;
    logic [1:0] dec_sel;
    logic bypass;
    logic user_coef;
    logic low_power;
    logic [2:0] dev_adr;
    logic coef_loaded;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic restart;
    logic [TAPS-1:0][DATA_W-1:0] hist;
    logic s2_odd;
    logic mac_busy;
    logic [3:0] mac_cnt;
    logic [MAC_W-1:0] mac_acc;
    logic [DATA_W-1:0] result;
    logic overrange;
    logic valid;
    logic [11:0] settle_cnt;
    logic [WORD_W-1:0] hold;
    logic pending;
    logic [WORD_W-1:0] shreg;
    ser_e ser;
    logic [4:0] bit_cnt;
    logic ready_n;
    logic frame_n;
    logic bit_out;
    logic bit_oe;
    logic latch;
  } state_s;
  state_s r, n;

  logic halve_n, rate_sel, edge_pol;
  logic internal_tick, fast_shift, shift_clk_nx, drive;
  logic hit, wr;
  logic [31:0] bmask, ctrl_cur, ctrl_new, rd;
  logic [2:0] d2_shift, tot_shift;
  logic s1_v, s2_v;
  logic [DATA_W-1:0] s1_d, s2_d;
  logic [TAP_AW-1:0] k;
  logic [COEF_W-1:0] coef, mem_rd;
  logic [MAC_W-1:0] mac_sum, scaled;
  logic [MAC_W-DATA_W:0] upper;
  logic new_res, ovr_now, filter_ok, cont_low, coef_wr;
  logic [DATA_W-1:0] res_data;
  logic [11:0] settle_target;
  logic [IRQ_W-1:0] events;
  logic [4:0] nb;

  // second flop only; the first stage is never read by logic
  assign halve_n = r.pin_sync[2];
  assign rate_sel = r.pin_sync[1];
  assign edge_pol = r.pin_sync[0];
  // master clock is clk/2; internal tick every 2 (x1) or 4 (x2) clocks
  assign internal_tick = halve_n ? r.div_cnt[0] : (r.div_cnt == 2'h3);
  assign fast_shift = halve_n | rate_sel;
  assign shift_clk_nx = fast_shift ? r.div_cnt[0] : r.div_cnt[1];
  assign drive = edge_pol ? (r.shift_clk & ~shift_clk_nx) : (~r.shift_clk & shift_clk_nx);
  assign hit = wb_req_i.cyc & wb_req_i.stb & ~r.ack;
  assign wr = hit & wb_req_i.we;
  assign bmask = {{8{wb_req_i.sel[3]}}, {8{wb_req_i.sel[2]}}, {8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};
  assign coef_wr = wr & wb_req_i.sel[0] & (wb_req_i.adr >= OFS_COEF) & (wb_req_i.adr <= OFS_COEF_END);
  assign d2_shift = STAGE2_SHIFT_MIN + 3'((r.dec_sel > DEC_SEL_MAX) ? DEC_SEL_MAX : r.dec_sel);
  assign tot_shift = STAGE1_SHIFT + d2_shift;
  assign filter_ok = ~r.user_coef | r.coef_loaded;
  // total decimation 32 leaves no idle shift period between frames, except with halve low and rate high
  assign cont_low = (tot_shift == STAGE1_SHIFT + STAGE2_SHIFT_MIN) & r.bypass
                    & ~(~halve_n & rate_sel);
  // twice the filter delay plus computation time, in internal ticks
  // shift amount widened to 4 bits: stage sum plus third stage reaches 10
  assign settle_target = (12'h001 << (r.bypass ? {1'b0, tot_shift} : {1'b0, tot_shift} + {1'b0, STAGE3_SHIFT}))
                         + COMP_DELAY_TICKS;
  assign k = TAP_AW'(r.mac_cnt - 4'h1);
  assign coef = r.user_coef ? mem_rd : DEF_COEF[k];
  assign mac_sum = r.mac_acc + MAC_W'($signed(r.hist[k]) * $signed(coef));
  assign scaled = MAC_W'($signed(mac_sum) >>> COEF_FRAC);
  assign upper = scaled[MAC_W-1:DATA_W-1];

  // modulator word enters stage one on every internal tick
  decim_stage u_stage1 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .restart_i(r.restart),
    .shift_i(STAGE1_SHIFT),
    .in_valid_i(internal_tick),
    .in_data_i({mod_sample_i, {(DATA_W-SAMPLE_W){1'b0}}}),
    .out_valid_o(s1_v),
    .out_data_o(s1_d)
  );

  decim_stage u_stage2 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .restart_i(r.restart),
    .shift_i(d2_shift),
    .in_valid_i(s1_v),
    .in_data_i(s1_d),
    .out_valid_o(s2_v),
    .out_data_o(s2_d)
  );

  coef_mem u_coef (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_en_i(coef_wr),
    .wr_addr_i(wb_req_i.adr[TAP_AW+1:2]),
    .wr_data_i(wb_req_i.dat[COEF_W-1:0]),
    .rd_addr_i(r.mac_cnt[TAP_AW-1:0]),
    .rd_data_o(mem_rd)
  );

  always_comb begin
    n = r;
    ctrl_cur = '0;
    ctrl_cur[CTRL_DEC_LSB +: 2] = r.dec_sel;
    ctrl_cur[CTRL_BYPASS] = r.bypass;
    ctrl_cur[CTRL_USER_COEF] = r.user_coef;
    ctrl_cur[CTRL_LOW_POWER] = r.low_power;
    ctrl_cur[CTRL_ADR_LSB +: 3] = r.dev_adr;
    ctrl_new = (ctrl_cur & ~bmask) | (wb_req_i.dat & bmask);
    rd = '0;
    new_res = 1'b0;
    ovr_now = 1'b0;
    res_data = r.result;
    nb = r.bit_cnt + 5'h01;
    n.pin_meta = {clock_halve_select_n_i, shift_rate_select_i, shift_edge_polarity_i};
    n.pin_sync = r.pin_meta;
    n.div_cnt = r.div_cnt + 2'h1;
    n.shift_clk = shift_clk_nx;
    n.ack = hit;
    n.restart = coef_wr;
    // a configuration write restarts the filter and its settling time
    if (wr && wb_req_i.adr == OFS_CTRL) begin
      n.dec_sel = ctrl_new[CTRL_DEC_LSB +: 2];
      n.bypass = ctrl_new[CTRL_BYPASS];
      n.user_coef = ctrl_new[CTRL_USER_COEF];
      n.low_power = ctrl_new[CTRL_LOW_POWER];
      n.dev_adr = ctrl_new[CTRL_ADR_LSB +: 3];
      n.restart = 1'b1;
    end
    if (wr && wb_req_i.adr == OFS_IRQ_MASK) n.irq_mask = ctrl_new[IRQ_W-1:0];
    if (coef_wr) n.coef_loaded = 1'b1;
    case (wb_req_i.adr)
      OFS_CTRL: rd = ctrl_cur;
      OFS_STATUS: begin
        rd[STAT_VALID] = r.valid;
        rd[STAT_OVERRANGE] = r.overrange;
        rd[STAT_FILTER_OK] = filter_ok;
        rd[STAT_BUSY] = r.ser != SER_IDLE;
      end
      OFS_IRQ_STAT: rd[IRQ_W-1:0] = r.irq_stat;
      OFS_IRQ_MASK: rd[IRQ_W-1:0] = r.irq_mask;
      OFS_RESULT: rd[DATA_W-1:0] = r.result;
      default: rd = '0;
    endcase
    n.rdata = hit ? rd : r.rdata;

    // third stage: keeps a tap history, computes every second word
    if (s2_v) begin
      n.hist = {r.hist[TAPS-2:0], s2_d};
      n.s2_odd = ~r.s2_odd;
      if (r.bypass) begin
        new_res = 1'b1;
        res_data = s2_d;
      end else if (r.s2_odd) begin
        n.mac_busy = 1'b1;
        n.mac_cnt = '0;
        n.mac_acc = '0;
      end
    end
    if (r.mac_busy) begin
      n.mac_cnt = r.mac_cnt + 4'h1;
      if (r.mac_cnt != 4'h0) n.mac_acc = mac_sum;
      if (r.mac_cnt == 4'(TAPS)) begin
        n.mac_busy = 1'b0;
        new_res = 1'b1;
        ovr_now = ~(&upper | ~|upper);
        res_data = ovr_now ? {scaled[MAC_W-1], {(DATA_W-1){~scaled[MAC_W-1]}}}
                           : scaled[DATA_W-1:0];
      end
    end
    if (r.restart) begin
      n.s2_odd = 1'b0;
      n.mac_busy = 1'b0;
      n.settle_cnt = '0;
    end else if (internal_tick && r.settle_cnt < settle_target) begin
      n.settle_cnt = r.settle_cnt + 12'h001;
    end
    n.valid = ~r.restart & (r.settle_cnt >= settle_target);
    if (new_res) begin
      n.result = res_data;
      n.overrange = ovr_now;
      n.hold = {res_data, r.dev_adr, r.valid, ovr_now, r.low_power, filter_ok};
    end

    // serial port: one ready period, then a 32-period frame
    n.latch = 1'b0;
    case (r.ser)
      SER_IDLE: begin
        if (drive && r.pending) begin
          n.ser = SER_READY;
          n.ready_n = 1'b0;
          n.shreg = r.hold;
          n.pending = 1'b0;
        end
      end
      SER_READY: begin
        if (drive) begin
          n.ser = SER_FRAME;
          n.ready_n = 1'b1;
          n.frame_n = 1'b0;
          n.bit_cnt = '0;
          n.bit_out = r.shreg[WORD_W-1];
          n.shreg = r.shreg << 1;
          n.bit_oe = 1'b1;
        end
      end
      SER_FRAME: begin
        n.latch = r.latch;
        if (drive) begin
          n.latch = 1'b0;
          if (r.bit_cnt == 5'(FRAME_LEN-1)) begin
            n.frame_n = 1'b1;
            n.bit_out = 1'b0;
            n.ser = SER_IDLE;
            if (r.pending) begin
              n.ser = SER_READY;
              n.ready_n = 1'b0;
              n.shreg = r.hold;
              n.pending = 1'b0;
            end
          end else begin
            n.bit_cnt = nb;
            n.bit_out = r.shreg[WORD_W-1];
            n.shreg = r.shreg << 1;
            n.bit_oe = nb != 5'(FRAME_LEN-1);
            n.latch = nb[3:0] == HALF_MARK;
          end
        end
      end
      default: n.ser = SER_IDLE;
    endcase
    if (new_res) n.pending = 1'b1;
    if (cont_low) n.frame_n = 1'b0;
    events = '0;
    events[IRQ_RESULT] = new_res;
    events[IRQ_OVERRANGE] = new_res & ovr_now;
    events[IRQ_VALID] = n.valid & ~r.valid;
    // a new event wins over a write-one-to-clear in the same cycle
    n.irq_stat = r.irq_stat & ~((wr && wb_req_i.adr == OFS_IRQ_STAT) ? ctrl_new[IRQ_W-1:0] : '0);
    n.irq_stat = n.irq_stat | events;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
      r.ready_n <= 1'b1;
      r.frame_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign wb_rsp_o.ack = r.ack;
  assign wb_rsp_o.dat = r.rdata;
  assign irq_o = |(r.irq_stat & r.irq_mask);
  assign mod_sample_take_o = internal_tick;
  assign shift_clock_out_o = r.shift_clk;
  assign result_bit_out_o = r.bit_out;
  assign result_bit_out_oe_o = r.bit_oe;
  assign result_ready_n_o = r.ready_n;
  assign frame_mark_out_n_o = r.frame_n;
  assign half_word_latch_out_o = r.latch;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // both compared clock samples must come from divide-by-1 logic
  AST_FAST_SHIFT: assert property ($past(halve_n) && $past(halve_n, 2)
    |-> shift_clock_out_o != $past(shift_clock_out_o))
    else $error("shift clock not at master rate in divide-by-1");
  AST_SLOW_TICK: assert property (internal_tick && !halve_n |=> (!internal_tick || halve_n) [*3])
    else $error("internal tick faster than half master clock");
  AST_READY_WIDTH: assert property ($fell(result_ready_n_o) && !fast_shift && $past(!fast_shift)
    |-> !result_ready_n_o [*4] ##1 result_ready_n_o)
    else $error("ready pulse not one slow shift period");
  AST_DRIVE_EDGE: assert property ($changed(result_bit_out_o) && $past(r.ser) == SER_FRAME
    |-> ($past(edge_pol) ? $fell(shift_clock_out_o) : $rose(shift_clock_out_o)))
    else $error("data changed on the sampling edge");
  AST_FRAME_START: assert property ($rose(result_ready_n_o) |-> !frame_mark_out_n_o && r.bit_cnt == 5'h00)
    else $error("frame did not start after ready");
  AST_FRAME_LEN: assert property ($rose(frame_mark_out_n_o) |-> $past(r.bit_cnt) == 5'(FRAME_LEN-1))
    else $error("frame did not last 32 shift periods");
  AST_LAST_RELEASED: assert property (r.ser == SER_FRAME && r.bit_cnt == 5'(FRAME_LEN-1)
    |-> !result_bit_out_oe_o)
    else $error("data driven in last frame period");
  AST_CONT_LOW: assert property (cont_low |=> !frame_mark_out_n_o)
    else $error("frame mark high in continuous mode");
  AST_LATCH: assert property (half_word_latch_out_o |-> r.ser == SER_FRAME && r.bit_cnt[3:0] == HALF_MARK)
    else $error("latch pulse off the 16-bit boundary");
  AST_VALID_WAIT: assert property (r.restart |=> !r.valid ##1 (r.settle_cnt <= 12'h001))
    else $error("valid not cleared by restart");
  AST_VALID_BIT: assert property ($past(new_res) |-> r.hold[3] == $past(r.valid))
    else $error("valid bit does not follow settling");

  COV_FRAME: cover property ($rose(frame_mark_out_n_o));
  COV_CONT: cover property (cont_low ##1 new_res);
  COV_VALID: cover property ($rose(r.valid));
endmodule : adc_result_serial_output
`default_nettype wire

/* result_capture_host.sv */
/*
  Host-side capture model for the serial result port: samples each bit on
  the sampling shift clock edge and publishes one record per ready pulse.
  Assumes the shift clock is slow enough to be seen as data on clk_i.
*/
`timescale 1ns/1ns
`default_nettype none
module result_capture_host (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic polarity_i,
  input wire logic sclk_i,
  input wire logic sdo_i,
  input wire logic drive_i,
  input wire logic frame_n_i,
  input wire logic ready_n_i,
  input wire logic latch_i,
  output logic [31:0] word_o,
  output logic [7:0] nbits_o,
  output logic [7:0] periods_o,
  output logic [7:0] rdy_clk_o,
  output logic [7:0] latches_o,
  output logic [15:0] gap_o,
  output logic [15:0] count_o
);
  logic sp, rp, lp, samp;
  logic [31:0] sh;
  logic [7:0] nb, per, rc, lc;
  logic [15:0] gc;
  // sample on the edge opposite to the driving one
  assign samp = polarity_i ? (sclk_i && !sp) : (!sclk_i && sp);
  always_ff @(posedge clk_i) begin
    sp <= sclk_i;
    rp <= ready_n_i;
    lp <= latch_i;
    if (rst_i) begin
      count_o <= 16'h0000;
      gc <= 16'h0000;
      rc <= 8'h00;
      lc <= 8'h00;
      per <= 8'h00;
      nb <= 8'h00;
    end else begin
      gc <= gc + 16'h0001;
      if (!ready_n_i) rc <= rc + 8'h01;
      if (latch_i && !lp) lc <= lc + 8'h01;
      if (samp && !frame_n_i) begin
        sh <= {sh[30:0], sdo_i};
        per <= per + 8'h01;
        if (drive_i) nb <= nb + 8'h01;
      end
      // publishing on ready keeps continuous-frame mode readable too
      if (rp && !ready_n_i) begin
        word_o <= sh;
        nbits_o <= nb;
        periods_o <= per;
        rdy_clk_o <= rc;
        latches_o <= lc;
        gap_o <= gc;
        count_o <= count_o + 16'h0001;
        gc <= 16'h0001;
        rc <= 8'h01;
        lc <= 8'h00;
        per <= 8'h00;
        nb <= 8'h00;
      end
    end
  end
endmodule : result_capture_host
`default_nettype wire

/* adc_result_serial_output_test.sv */
/*
  Self-checking bench for the result port: Wishbone tasks, pin modes,
  frame format, settling, output rates and interrupt.
  Assumes zero modulator input gives a zero result word.
*/
`timescale 1ns/1ns
`default_nettype none
module adc_result_serial_output_test;
  import adc_serial_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  wb_req_s req = '0;
  wb_rsp_s rsp;
  logic irq, take, sclk, result_bit_out, oe, rdy_n, frame_n, latch, sdo_last, sdo_wire;
  logic halve_n = 1'b1;
  logic rate = 1'b0;
  logic pol = 1'b0;
  logic [15:0] mod = 16'h0000;
  logic [31:0] word, q, n;
  logic [7:0] nbits, pers, rclk, lats;
  logic [15:0] gap, count;
  logic [7:0] ctl [4] = '{8'h04, 8'h00, 8'h01, 8'h02};
  int errors = 0;
  int checks = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  // released line shows the inverse of its last driven level
  always @(posedge clk) if (oe) sdo_last <= result_bit_out;
  assign sdo_wire = oe ? result_bit_out : !sdo_last;
  adc_result_serial_output dut_u (.clk_i(clk), .rst_i(rst), .wb_req_i(req), .wb_rsp_o(rsp), .irq_o(irq),
    .mod_sample_i(mod), .mod_sample_take_o(take), .clock_halve_select_n_i(halve_n),
    .shift_rate_select_i(rate), .shift_edge_polarity_i(pol), .shift_clock_out_o(sclk),
    .result_bit_out_o(result_bit_out), .result_bit_out_oe_o(oe), .result_ready_n_o(rdy_n),
    .frame_mark_out_n_o(frame_n), .half_word_latch_out_o(latch));
  result_capture_host host_u (.clk_i(clk), .rst_i(rst), .polarity_i(pol), .sclk_i(sclk), .sdo_i(sdo_wire),
    .drive_i(oe), .frame_n_i(frame_n), .ready_n_i(rdy_n), .latch_i(latch), .word_o(word),
    .nbits_o(nbits), .periods_o(pers), .rdy_clk_o(rclk), .latches_o(lats), .gap_o(gap), .count_o(count));
  task end_of_test;
    if (errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      errors++;
      end_of_test();
    end
  end
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    req.cyc <= 1'b1;
    req.stb <= 1'b1;
    req.we <= we;
    req.adr <= adr;
    req.sel <= 4'hF;
    req.dat <= dat;
    @(posedge clk);
    while (rsp.ack !== 1'b1) @(posedge clk);
    q = rsp.dat;
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
    req.we <= 1'b0;
    @(posedge clk);
  endtask : wb
  task frames(input int k);
    logic [15:0] c;
    repeat (k) begin
      c = count;
      while (count === c) @(posedge clk);
    end
  endtask : frames
  // clk cycles between two rising edges of shift clock or tick strobe
  task period(input logic which);
    logic prev, s;
    for (int i = 0; i < 2; i++) begin
      n = 0;
      do begin
        prev = which ? take : sclk;
        @(posedge clk);
        n++;
        s = which ? take : sclk;
      end while (!(s && !prev));
    end
  endtask : period
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl_reset", q, 32'h0);
    wb(1'b0, OFS_IRQ_MASK, 32'h0);
    chk("mask_reset", q, 32'h0);
    wb(1'b1, 8'h80, 32'hFFFFFFFF);
    wb(1'b0, 8'h80, 32'h0);
    chk("unmapped", q, 32'h0);
    for (int i = 0; i < 4; i++) begin
      halve_n <= i[1];
      rate <= i[0];
      repeat (20) @(posedge clk);
      period(1'b0);
      chk("shift_period", n, (i == 0) ? 32'h4 : 32'h2);
      period(1'b1);
      chk("tick_period", n, i[1] ? 32'h2 : 32'h4);
    end
    halve_n <= 1'b1;
    rate <= 1'b0;
    wb(1'b1, OFS_CTRL, 32'hB0);
    frames(2);
    chk("restart_valid", word[4], 32'h0);
    frames(16);
    for (int p = 0; p < 2; p++) begin
      chk("data", word[31:8], 32'h0);
      chk("status", word[7:1], 32'h5B);
      chk("driven_bits", nbits, 32'd31);
      chk("frame_len", pers, 32'd32);
      chk("ready_len", rclk, 32'h2);
      chk("latches", lats, 32'h2);
      chk("gap", gap, 32'd128);
      pol <= 1'b1;
      frames(3);
    end
    wb(1'b0, OFS_STATUS, 32'h0);
    chk("stat_valid", q[STAT_VALID], 32'h1);
    pol <= 1'b0;
    mod <= 16'h8000;
    frames(12);
    chk("sign", word[31:8], 32'h800000);
    mod <= 16'h0000;
    halve_n <= 1'b0;
    rate <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, OFS_CTRL, {24'h0, ctl[i]});
      frames(3);
      chk("rate_gap", gap, 32'h80 << i);
      chk("rate_bits", nbits, 32'd31);
    end
    halve_n <= 1'b1;
    wb(1'b1, OFS_CTRL, 32'h04);
    repeat (200) @(posedge clk);
    n = 0;
    repeat (300) begin
      @(posedge clk);
      if (frame_n !== 1'b0) n++;
    end
    chk("frame_cont", n, 32'h0);
    wb(1'b1, OFS_CTRL, 32'h00);
    wb(1'b1, OFS_IRQ_STAT, 32'h7);
    frames(1);
    wb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk("irq_stat", q[IRQ_RESULT], 32'h1);
    chk("irq_masked", irq, 32'h0);
    wb(1'b1, OFS_IRQ_MASK, 32'h1);
    chk("irq_on", irq, 32'h1);
    frames(1);
    wb(1'b1, OFS_IRQ_STAT, 32'h1);
    chk("irq_clr", irq, 32'h0);
    wb(1'b1, OFS_CTRL, 32'h08);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk("filter_ok_off", q[STAT_FILTER_OK], 32'h0);
    for (int i = 0; i < TAPS; i++) wb(1'b1, OFS_COEF + 8'(4 * i), 32'h7F);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk("filter_ok_on", q[STAT_FILTER_OK], 32'h1);
    mod <= 16'h8000;
    frames(12);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk("overrange", q[STAT_OVERRANGE], 32'h1);
    chk("ovr_bit", word[3], 32'h1);
    wb(1'b0, OFS_RESULT, 32'h0);
    chk("saturated", q, 32'h800000);
    end_of_test();
  end
endmodule : adc_result_serial_output_test
`default_nettype wire
